/* include/arp_match_defs.svh */
// Constant definitions for the ARP/RARP entry field matcher.
`ifndef ARP_MATCH_DEFS_SVH
`define ARP_MATCH_DEFS_SVH

// ----------------------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------------------
`define OFS_CFG        4'h0
`define OFS_SIP_ADDR   4'h1
`define OFS_SIP_MASK   4'h2
`define OFS_TIP_ADDR   4'h3
`define OFS_TIP_MASK   4'h4
`define OFS_STATUS     4'h5

// ----------------------------------------------------------------------------
// Configuration field positions (ARP select is one bit, every other selector is two bits wide)
// ----------------------------------------------------------------------------
`define CFG_ARPSEL_BIT 0
`define CFG_OPSEL_LSB  1
`define CFG_RRSEL_LSB  3
`define CFG_SIP_LSB    5
`define CFG_TIP_LSB    7
`define CFG_SHA_LSB    9
`define CFG_THA_LSB    11
`define CFG_LEN_LSB    13
`define CFG_HRD_LSB    15
`define CFG_PRO_LSB    17
`define CFG_USED_MSB   18

// ----------------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------------
`define STS_MATCH_BIT  0
`define STS_SEEN_BIT   1
`define STS_CNT_LSB    16

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_CFG        32'h0000_0000
`define RST_WORD       32'h0000_0000

// ----------------------------------------------------------------------------
// Header field values
// ----------------------------------------------------------------------------
`define OP_ARP_REQ     16'h0001
`define OP_ARP_REP     16'h0002
`define OP_RARP_REQ    16'h0003
`define OP_RARP_REP    16'h0004
`define HW_LEN_ETH     8'h06
`define PROTO_LEN_IP4  8'h04
`define HW_TYPE_ETH    16'h0001
`define PROTO_TYPE_IP4 16'h0800

`endif

/* include/arp_match_pkg.sv */
// Types shared by the ARP/RARP entry field matcher.
`default_nettype none
package arp_match_pkg;
  // Three-way check: ignore, condition must be false, condition must be true.
  typedef enum logic [1:0] {TRI_ANY = 2'h0, TRI_ZERO = 2'h1, TRI_ONE = 2'h2, TRI_RSVD = 2'h3} triSel_t;
  // Opcode class selector.
  typedef enum logic [1:0] {OPC_ANY = 2'h0, OPC_ARP = 2'h1, OPC_RARP = 2'h2, OPC_OTHER = 2'h3} opSel_t;
  // Request or reply selector.
  typedef enum logic [1:0] {RR_ANY = 2'h0, RR_REQ = 2'h1, RR_REP = 2'h2, RR_RSVD = 2'h3} rrSel_t;
  // Protocol address filter mode.
  typedef enum logic [1:0] {IPM_ANY = 2'h0, IPM_HOST = 2'h1, IPM_NET = 2'h2, IPM_RSVD = 2'h3} ipMode_t;
endpackage
`default_nettype wire

/* rtl/arp_rarp_ace_field_matcher.sv */
// ARP/RARP entry field matcher with an Avalon-MM register slave.
//
// Contract
// - ARP checks apply only for ARP frame type.
// - Opcode class: any, ARP, RARP or other.
// - Opcode kind: any, request or reply.
// - Sender address: any, host or network.
// - Target address: any, host or network.
// - Sender hardware equals source MAC, tri-state.
// - Target hardware equals destination MAC, tri-state.
// - Lengths six and four, tri-state.
// - Hardware type equals one, tri-state.
// - Protocol type equals 0x800, tri-state.
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`include "arp_match_defs.svh"
`default_nettype none
module arp_rarp_ace_field_matcher
  import arp_match_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        frmValid,
  input  wire logic [15:0] opcode,
  input  wire logic [15:0] hwType,
  input  wire logic [15:0] protoType,
  input  wire logic [7:0]  hwLen,
  input  wire logic [7:0]  protoLen,
  input  wire logic [47:0] senderHwAddr,
  input  wire logic [31:0] senderIp,
  input  wire logic [47:0] targetHwAddr,
  input  wire logic [31:0] targetIp,
  input  wire logic [47:0] srcMac,
  input  wire logic [47:0] dstMac,
  output logic             matchValid,
  output logic             match
);

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------

  // Evaluates a three-way check against a condition.
  function automatic logic triOk(input logic [1:0] sel, input logic cond);
    case (sel)
      TRI_ZERO: triOk = !cond;
      TRI_ONE:  triOk = cond;
      default:  triOk = 1'b1;
    endcase
  endfunction

  // Evaluates a protocol address filter in host or network mode.
  function automatic logic ipOk(input logic [1:0] mode, input logic [31:0] ip,
                                input logic [31:0] cfgAddr, input logic [31:0] cfgMask);
    case (mode)
      IPM_HOST: ipOk = (ip == cfgAddr);
      IPM_NET:  ipOk = (((ip ^ cfgAddr) & cfgMask) == 32'h0000_0000);
      default:  ipOk = 1'b1;
    endcase
  endfunction

  // Merges write data into a word under the byte enables.
  function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    beMerge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        beMerge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Register slave
  // --------------------------------------------------------------------------
  logic [31:0]      cfg_ff,     nxt_cfg;
  logic [31:0]      sipAddr_ff, nxt_sipAddr;
  logic [31:0]      sipMask_ff, nxt_sipMask;
  logic [31:0]      tipAddr_ff, nxt_tipAddr;
  logic [31:0]      tipMask_ff, nxt_tipMask;
  logic [31:0]      rdata_ff,   nxt_rdata;
  logic             waitReq_ff, nxt_waitReq;
  logic             match_ff,   nxt_match;
  logic             mValid_ff,  nxt_mValid;
  logic             seen_ff,    nxt_seen;
  logic [CNT_W-1:0] count_ff,   nxt_count;
  logic [31:0]      statusWord;
  logic             wrTake;

  // A write lands only on the edge where waitrequest is seen low.
  assign wrTake = write && !waitReq_ff;

  // Status word built from the block's own match history.
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`STS_MATCH_BIT] = match_ff;
    statusWord[`STS_SEEN_BIT] = seen_ff;
    statusWord[`STS_CNT_LSB +: CNT_W] = count_ff;
  end

  // Next state of the bus handshake, read data and configuration.
  always_comb begin
    nxt_waitReq = !((read || write) && waitReq_ff);
    nxt_rdata   = rdata_ff;
    nxt_cfg     = cfg_ff;
    nxt_sipAddr = sipAddr_ff;
    nxt_sipMask = sipMask_ff;
    nxt_tipAddr = tipAddr_ff;
    nxt_tipMask = tipMask_ff;
    if (read && waitReq_ff) begin
      case (address)
        `OFS_CFG:      nxt_rdata = {13'h0, cfg_ff[`CFG_USED_MSB:0]};
        `OFS_SIP_ADDR: nxt_rdata = sipAddr_ff;
        `OFS_SIP_MASK: nxt_rdata = sipMask_ff;
        `OFS_TIP_ADDR: nxt_rdata = tipAddr_ff;
        `OFS_TIP_MASK: nxt_rdata = tipMask_ff;
        `OFS_STATUS:   nxt_rdata = statusWord;
        default:       nxt_rdata = 32'h0000_0000;
      endcase
    end
    if (wrTake) begin
      case (address)
        `OFS_CFG:      nxt_cfg = beMerge(cfg_ff, writedata, byteenable) & 32'h0007_ffff;
        `OFS_SIP_ADDR: nxt_sipAddr = beMerge(sipAddr_ff, writedata, byteenable);
        `OFS_SIP_MASK: nxt_sipMask = beMerge(sipMask_ff, writedata, byteenable);
        `OFS_TIP_ADDR: nxt_tipAddr = beMerge(tipAddr_ff, writedata, byteenable);
        `OFS_TIP_MASK: nxt_tipMask = beMerge(tipMask_ff, writedata, byteenable);
        default:       nxt_cfg = cfg_ff;
      endcase
    end
  end

  // Registers of the bus slave.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      waitReq_ff <= 1'b1;
      rdata_ff   <= `RST_WORD;
      cfg_ff     <= `RST_CFG;
      sipAddr_ff <= `RST_WORD;
      sipMask_ff <= `RST_WORD;
      tipAddr_ff <= `RST_WORD;
      tipMask_ff <= `RST_WORD;
    end else begin
      waitReq_ff <= nxt_waitReq;
      rdata_ff   <= nxt_rdata;
      cfg_ff     <= nxt_cfg;
      sipAddr_ff <= nxt_sipAddr;
      sipMask_ff <= nxt_sipMask;
      tipAddr_ff <= nxt_tipAddr;
      tipMask_ff <= nxt_tipMask;
    end
  end

  assign readdata    = rdata_ff;
  assign waitrequest = waitReq_ff;

  // --------------------------------------------------------------------------
  // Field checks
  // --------------------------------------------------------------------------
  logic [1:0] opSel, rrSel, sipMode, tipMode, shaSel, thaSel, lenSel, hrdSel, proSel;
  logic       arpSel, isArpOp, isRarpOp, isReq, isRep;
  logic       okOp, okRr, okSip, okTip, okSha, okTha, okLen, okHrd, okPro, arpAll;

  // Configuration selectors.
  assign arpSel  = cfg_ff[`CFG_ARPSEL_BIT];
  assign opSel   = cfg_ff[`CFG_OPSEL_LSB +: 2];
  assign rrSel   = cfg_ff[`CFG_RRSEL_LSB +: 2];
  assign sipMode = cfg_ff[`CFG_SIP_LSB +: 2];
  assign tipMode = cfg_ff[`CFG_TIP_LSB +: 2];
  assign shaSel  = cfg_ff[`CFG_SHA_LSB +: 2];
  assign thaSel  = cfg_ff[`CFG_THA_LSB +: 2];
  assign lenSel  = cfg_ff[`CFG_LEN_LSB +: 2];
  assign hrdSel  = cfg_ff[`CFG_HRD_LSB +: 2];
  assign proSel  = cfg_ff[`CFG_PRO_LSB +: 2];

  // Opcode classification.
  assign isArpOp  = (opcode == `OP_ARP_REQ) || (opcode == `OP_ARP_REP);
  assign isRarpOp = (opcode == `OP_RARP_REQ) || (opcode == `OP_RARP_REP);
  assign isReq    = (opcode == `OP_ARP_REQ) || (opcode == `OP_RARP_REQ);
  assign isRep    = (opcode == `OP_ARP_REP) || (opcode == `OP_RARP_REP);

  // Opcode class check.
  always_comb begin
    case (opSel)
      OPC_ARP:   okOp = isArpOp;
      OPC_RARP:  okOp = isRarpOp;
      OPC_OTHER: okOp = !isArpOp && !isRarpOp;
      default:   okOp = 1'b1;
    endcase
  end

  // Request or reply check.
  always_comb begin
    case (rrSel)
      RR_REQ:  okRr = isReq;
      RR_REP:  okRr = isRep;
      default: okRr = 1'b1;
    endcase
  end

  // Address and header field checks.
  assign okSip = ipOk(sipMode, senderIp, sipAddr_ff, sipMask_ff);
  assign okTip = ipOk(tipMode, targetIp, tipAddr_ff, tipMask_ff);
  assign okSha = triOk(shaSel, senderHwAddr == srcMac);
  assign okTha = triOk(thaSel, targetHwAddr == dstMac);
  assign okLen = triOk(lenSel, (hwLen == `HW_LEN_ETH) && (protoLen == `PROTO_LEN_IP4));
  assign okHrd = triOk(hrdSel, hwType == `HW_TYPE_ETH);
  assign okPro = triOk(proSel, protoType == `PROTO_TYPE_IP4);
  assign arpAll = okOp && okRr && okSip && okTip && okSha && okTha && okLen && okHrd && okPro;

  // --------------------------------------------------------------------------
  // Match result
  // --------------------------------------------------------------------------

  // Next match result, valid strobe and history.
  always_comb begin
    nxt_mValid = frmValid;
    nxt_match  = match_ff;
    nxt_seen   = seen_ff;
    nxt_count  = count_ff;
    if (frmValid) begin
      nxt_match = !arpSel || arpAll;
      nxt_seen  = 1'b1;
      if (!arpSel || arpAll) begin
        nxt_count = count_ff + 1'b1;
      end
    end
  end

  // Registers of the match result.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mValid_ff <= 1'b0;
      match_ff  <= 1'b0;
      seen_ff   <= 1'b0;
      count_ff  <= '0;
    end else begin
      mValid_ff <= nxt_mValid;
      match_ff  <= nxt_match;
      seen_ff   <= nxt_seen;
      count_ff  <= nxt_count;
    end
  end

  assign matchValid = mValid_ff;
  assign match      = match_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_NOT_ARP: assert property (frmValid && !arpSel |=> matchValid && match)
    else $error("Non-ARP entry did not match.");
  AST_OP_RARP: assert property (frmValid && arpSel && opSel == OPC_RARP && opcode == `OP_ARP_REQ |=> !match)
    else $error("ARP opcode matched a RARP-only entry.");
  AST_OP_OTHER: assert property (frmValid && arpSel && opSel == OPC_OTHER && opcode == `OP_RARP_REP |=> !match)
    else $error("Known opcode matched an other-only entry.");
  AST_RR_REP: assert property (frmValid && arpSel && rrSel == RR_REP && opcode == `OP_RARP_REQ |=> !match)
    else $error("Request matched a reply-only entry.");
  AST_SIP_HOST: assert property (frmValid && arpSel && sipMode == IPM_HOST && senderIp != sipAddr_ff |=> !match)
    else $error("Sender address mismatch matched in host mode.");
  AST_TIP_NET: assert property (frmValid && arpSel && tipMode == IPM_NET
                                && ((targetIp ^ tipAddr_ff) & tipMask_ff) != 32'h0000_0000 |=> !match)
    else $error("Target address mismatch matched in network mode.");
  AST_NET_ALL: assert property (frmValid && arpSel && cfg_ff[`CFG_USED_MSB:1] == 18'h00020
                                && ((senderIp ^ sipAddr_ff) & sipMask_ff) == 32'h0000_0000 |=> match)
    else $error("Masked-equal sender address did not match.");
  AST_SHA: assert property (frmValid && arpSel && shaSel == TRI_ZERO && senderHwAddr == srcMac |=> !match)
    else $error("Equal sender hardware address matched a must-differ entry.");
  AST_THA: assert property (frmValid && arpSel && thaSel == TRI_ONE && targetHwAddr != dstMac |=> !match)
    else $error("Differing target hardware address matched.");
  AST_LEN: assert property (frmValid && arpSel && lenSel == TRI_ONE && hwLen != `HW_LEN_ETH |=> !match)
    else $error("Wrong hardware length matched.");
  AST_HRD: assert property (frmValid && arpSel && hrdSel == TRI_ZERO && hwType == `HW_TYPE_ETH |=> !match)
    else $error("Ethernet hardware type matched a must-not entry.");
  AST_PRO: assert property (frmValid && arpSel && proSel == TRI_ONE && protoType != `PROTO_TYPE_IP4 |=> !match)
    else $error("Wrong protocol type matched.");
  AST_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("Bus answer was not a single cycle.");
  AST_VALID: assert property (frmValid |=> matchValid)
    else $error("Match strobe did not follow a frame.");

endmodule
`default_nettype wire

/* tb/frame_src.sv */
// Header source standing in for the switch frame parser.
`default_nettype none
module frame_src (
  input  wire logic        clock,
  output logic             frmValid,
  output logic [15:0]      opcode,
  output logic [15:0]      hwType,
  output logic [15:0]      protoType,
  output logic [7:0]       hwLen,
  output logic [7:0]       protoLen,
  output logic [47:0]      senderHwAddr,
  output logic [47:0]      targetHwAddr,
  output logic [47:0]      srcMac,
  output logic [47:0]      dstMac,
  output logic [31:0]      senderIp,
  output logic [31:0]      targetIp
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet start with all fields defined.
  initial begin
    frmValid = 1'h0;
    {opcode, hwType, protoType, hwLen, protoLen} = '0;
    {senderHwAddr, targetHwAddr, srcMac, dstMac, senderIp, targetIp} = '0;
  end

  // Shows one header for one cycle; stale fields are inverted so nothing leans on them.
  task automatic send(input logic [15:0] op, ht, pt, input logic [7:0] hl, pl,
                      input logic [47:0] sha, tha, sm, dm, input logic [31:0] sip, tip);
    @(posedge clock);
    frmValid <= 1'h1;
    {opcode, hwType, protoType, hwLen, protoLen} <= {op, ht, pt, hl, pl};
    {senderHwAddr, targetHwAddr, srcMac, dstMac, senderIp, targetIp} <= {sha, tha, sm, dm, sip, tip};
    @(posedge clock);
    frmValid <= 1'h0;
    {opcode, hwType, protoType, hwLen, protoLen} <= ~{op, ht, pt, hl, pl};
    {senderHwAddr, targetHwAddr, srcMac, dstMac, senderIp, targetIp} <= ~{sha, tha, sm, dm, sip, tip};
  endtask
endmodule
`default_nettype wire

/* tb/arp_rarp_ace_field_matcher_tb.sv */
// Self-checking bench for the ARP/RARP entry field matcher.
`include "arp_match_defs.svh"
`default_nettype none
module arp_rarp_ace_field_matcher_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import arp_match_pkg::*;
  localparam logic [47:0] SM = 48'h0200_0000_00a1;
  localparam logic [47:0] DM = 48'h0200_0000_00b2;
  localparam logic [31:0] SIPA = 32'h0a00_0005;
  localparam logic [31:0] SIPM = 32'hffff_ff00;
  localparam logic [31:0] TIPA = 32'hc0a8_0101;
  localparam logic [31:0] TIPM = 32'h00ff_ffff;
  logic        clock, resetn, read, write, waitrequest, frmValid, matchValid, match;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, senderIp, targetIp, sip, tip, c;
  logic [15:0] opcode, hwType, protoType, op, ht, pt, expCnt;
  logic [7:0]  hwLen, protoLen, hl, pl;
  logic [47:0] senderHwAddr, targetHwAddr, srcMac, dstMac, sha, tha;
  logic        expLast;
  int          n_fail, cmp_count, i, p, v, k;
  logic [31:0] mix [3] = '{32'h0007_fffe, 32'h0005_5555, 32'h0002_aaab};

  // Clock at 200 MHz.
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  frame_src src (.clock(clock), .frmValid(frmValid), .opcode(opcode), .hwType(hwType),
    .protoType(protoType), .hwLen(hwLen), .protoLen(protoLen), .senderHwAddr(senderHwAddr),
    .targetHwAddr(targetHwAddr), .srcMac(srcMac), .dstMac(dstMac), .senderIp(senderIp),
    .targetIp(targetIp));

  arp_rarp_ace_field_matcher #(.CNT_W(16)) dut (.clock(clock), .resetn(resetn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .frmValid(frmValid), .opcode(opcode), .hwType(hwType),
    .protoType(protoType), .hwLen(hwLen), .protoLen(protoLen), .senderHwAddr(senderHwAddr),
    .senderIp(senderIp), .targetHwAddr(targetHwAddr), .targetIp(targetIp), .srcMac(srcMac),
    .dstMac(dstMac), .matchValid(matchValid), .match(match));

  // ----------------------------------------------------------------------------
  // Reporting and bus access
  // ----------------------------------------------------------------------------
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One Avalon transfer held until waitrequest is sampled low.
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    @(posedge clock);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= d;
    byteenable <= be;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (waitrequest === 1'h0) break;
    end
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
    if (n == 20) begin
      n_fail++;
      conclude();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    logic [31:0] q;
    bus(a, 1'h1, d, be, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'h0, 32'h0, 4'hf, q);
    chk(q, e);
  endtask

  // ----------------------------------------------------------------------------
  // Reference decision and frames
  // ----------------------------------------------------------------------------
  // Three-way selector: 1 wants the condition false, 2 wants it true.
  function automatic logic tri3(input logic [1:0] s, input logic cnd);
    return (s == 2'h1) ? !cnd : (s == 2'h2) ? cnd : 1'h1;
  endfunction

  // Host compares every bit; network compares only where the mask is set.
  function automatic logic ipf(input logic [1:0] m, input logic [31:0] a, ra, rm);
    return (m == 2'h1) ? (a == ra) : (m == 2'h2) ? (((a ^ ra) & rm) == 32'h0) : 1'h1;
  endfunction

  function automatic logic model(input logic [31:0] cf);
    logic arp, rarp, oc, rr;
    arp = (op == 16'h1) || (op == 16'h2);
    rarp = (op == 16'h3) || (op == 16'h4);
    oc = (cf[2:1] == 2'h1) ? arp : (cf[2:1] == 2'h2) ? rarp : (cf[2:1] == 2'h3) ? !(arp || rarp) : 1'h1;
    rr = (cf[4:3] == 2'h1) ? (op == 16'h1 || op == 16'h3) : (cf[4:3] == 2'h2) ? (op == 16'h2 || op == 16'h4) : 1'h1;
    return !cf[0] || (oc && rr && ipf(cf[6:5], sip, SIPA, SIPM) && ipf(cf[8:7], tip, TIPA, TIPM)
      && tri3(cf[10:9], sha == SM) && tri3(cf[12:11], tha == DM)
      && tri3(cf[14:13], hl == 8'h06 && pl == 8'h04) && tri3(cf[16:15], ht == 16'h0001)
      && tri3(cf[18:17], pt == 16'h0800));
  endfunction

  // Builds header number k: a plain ARP request, then variants that each break some fields.
  task automatic pick(input int kk);
    op = 16'h0001;
    ht = 16'h0001;
    pt = 16'h0800;
    hl = 8'h06;
    pl = 8'h04;
    sha = SM;
    tha = DM;
    sip = SIPA;
    tip = TIPA;
    case (kk)
      1: begin
        op = 16'h0002;
        sha = SM ^ 48'h1;
        tip = 32'hc0a9_0101;
      end
      2: begin
        op = 16'h0003;
        hl = 8'h08;
        tha = ~DM;
        sip = 32'h0a01_0005;
      end
      3: begin
        op = 16'h0004;
        ht = 16'h0006;
        pt = 16'h86dd;
        sip = 32'h0a00_0077;
      end
      4: begin
        op = 16'h0005;
        pl = 8'h10;
        tip = 32'h40a8_0101;
      end
      default: ;
    endcase
  endtask

  // Sends one header and checks the one-cycle answer.
  task automatic frame(input logic [31:0] cf, input int kk);
    pick(kk);
    src.send(op, ht, pt, hl, pl, sha, tha, SM, DM, sip, tip);
    @(posedge clock);
    chk({31'h0, matchValid}, 32'h1);
    chk({31'h0, match}, {31'h0, model(cf)});
    expCnt += {15'h0, model(cf)};
    expLast = model(cf);
    @(posedge clock);
    chk({31'h0, matchValid}, 32'h0);
  endtask

  // Main sequence: reset, register map, then every selector value against every header.
  initial begin
    n_fail = 0;
    cmp_count = 0;
    expCnt = 16'h0;
    expLast = 1'h0;
    resetn = 1'h0;
    read = 1'h0;
    write = 1'h0;
    address = 4'h0;
    writedata = 32'h0;
    byteenable = 4'h0;
    repeat (10) @(posedge clock);
    resetn <= 1'h1;
    chk({31'h0, waitrequest}, 32'h1);
    for (i = 0; i < 6; i++) rd(4'(i), 32'h0);
    wr(`OFS_CFG, 32'hffff_ffff);
    rd(`OFS_CFG, 32'h0007_ffff);
    wr(`OFS_CFG, 32'h0, 4'h2);
    rd(`OFS_CFG, 32'h0007_00ff);
    wr(4'h6, 32'h1234_5678);
    rd(4'h6, 32'h0);
    wr(`OFS_STATUS, 32'hffff_ffff);
    rd(`OFS_STATUS, 32'h0);
    wr(`OFS_SIP_ADDR, SIPA);
    wr(`OFS_SIP_MASK, SIPM);
    wr(`OFS_TIP_ADDR, TIPA);
    wr(`OFS_TIP_MASK, TIPM);
    rd(`OFS_TIP_MASK, TIPM);
    for (p = 1; p < 19; p += 2) begin
      for (v = 0; v < 4; v++) begin
        c = 32'h1 | (32'(v) << p);
        wr(`OFS_CFG, c);
        for (k = 0; k < 5; k++) frame(c, k);
      end
    end
    for (i = 0; i < 3; i++) begin
      wr(`OFS_CFG, mix[i]);
      for (k = 0; k < 5; k++) frame(mix[i], k);
    end
    rd(`OFS_STATUS, {expCnt, 14'h0, 1'h1, expLast});
    conclude();
  end
endmodule
`default_nettype wire
